/* hdl/afpb_bank.sv */
/*
  Acyclic parameter bank of the fieldbus option card: control outputs,
  mirrored feedback, multiport setup, start-up parameterisation store and
  the data logger view. Assumes every input is produced by logic on clk.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Interface type reads a fixed code only.
// - Start-up loads parameters 1 to 19.
// - Load only when permit equals 1.
// - Permit resets to 1.
// - Command and position demand stored as cyclic.
// - Port command stored as cyclic port command.
// - Output bits 0-3 drive relays 1-4.
// - Bits 10/11 zero open/close start counters.
// - Bit 12 clears data logger torque points and start counters; torque limits kept.
// - Feedback parameters mirror cyclic inputs.
// - Analogue scale is a writable setting.
// - Multiport position mirrors cyclic feedback.
// - Port count accepts only 2 to 10.
// - Active mask bit n marks port n+1.
// - Port 1 always active.
// - Selected configuration set at start-up only.
// - Log refreshed after stop, remote only.
// - Torque limits close then open.
// - Eleven opening torque points, 0 to 100%.
// - Eleven closing torque points, 100 to 0%.
// - Close and open start counters, resettable.
module afpb_bank
  import afpb_pkg::*;
#(
  parameter int SETTLE_CYCLES = LOG_SETTLE_CYCLES,
  // Arbitrary neutral value
  parameter logic [15:0] IFACE_TYPE_CODE = 16'h00A5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Parameter access
  input wire logic [AFPB_AW-1:0] par_addr,
  input wire logic [AFPB_DW-1:0] par_wdata,
  input wire logic par_wr,
  input wire logic par_rd,
  output logic [AFPB_DW-1:0] par_rdata,
  // Start-up from the fieldbus_option_card
  input wire logic startup_wr,
  input wire logic [AFPB_AW-1:0] startup_index,
  input wire logic [AFPB_DW-1:0] startup_data,
  input wire logic startup_cfg_valid,
  input wire logic [AFPB_DW-1:0] startup_cfg,
  // Cyclic feedback
  input wire logic [AFPB_DW-1:0] fb_status_a,
  input wire logic [AFPB_DW-1:0] fb_status_b,
  input wire logic [AFPB_DW-1:0] fb_torque,
  input wire logic [AFPB_DW-1:0] fb_position,
  input wire logic [AFPB_DW-1:0] fb_temperature,
  input wire logic [AFPB_DW-1:0] fb_analogue,
  input wire logic [AFPB_DW-1:0] fb_multiport,
  // Logger sources
  input wire logic act_moving,
  input wire logic act_remote,
  input wire logic [AFPB_DW-1:0] torque_limit_close,
  input wire logic [AFPB_DW-1:0] torque_limit_open,
  input wire logic open_torque_valid,
  input wire logic close_torque_valid,
  input wire logic [3:0] torque_point,
  input wire logic [AFPB_DW-1:0] torque_value,
  input wire logic start_close,
  input wire logic start_open,
  // Control outputs
  output logic [AFPB_DW-1:0] actuator_command,
  output logic [AFPB_DW-1:0] position_demand,
  output logic command_strobe,
  output logic [AFPB_DW-1:0] port_command,
  output logic port_strobe,
  output logic [OUT_RELAY_W-1:0] relay_out,
  output logic [AFPB_DW-1:0] analogue_scale,
  output logic [AFPB_DW-1:0] port_count,
  output logic [AFPB_DW-1:0] active_port_mask,
  output logic [AFPB_DW-1:0] startup_value_out [STARTUP_COUNT]
);

  // Settings group
  logic [AFPB_DW-1:0] permit_q, permit_d;
  logic [AFPB_DW-1:0] cmd_q, cmd_d;
  logic [AFPB_DW-1:0] demand_q, demand_d;
  logic cmd_stb_q, cmd_stb_d;
  logic [AFPB_DW-1:0] portcmd_q, portcmd_d;
  logic port_stb_q, port_stb_d;
  logic [OUT_RELAY_W-1:0] relay_q, relay_d;
  logic [AFPB_DW-1:0] scale_q, scale_d;
  logic [AFPB_DW-1:0] pcount_q, pcount_d;
  logic [AFPB_DW-1:0] pmask_q, pmask_d;
  logic [AFPB_DW-1:0] config_q, config_d;
  logic [AFPB_DW-1:0] startup_q [STARTUP_COUNT];
  logic [AFPB_DW-1:0] startup_d [STARTUP_COUNT];
  logic [AFPB_DW-1:0] rdata_q, rdata_d;

  // Logger group
  afpb_log_state_t state_q, state_d;
  logic [31:0] settle_q, settle_d;
  logic [AFPB_DW-1:0] live_open_q [TORQUE_POINTS];
  logic [AFPB_DW-1:0] live_open_d [TORQUE_POINTS];
  logic [AFPB_DW-1:0] live_close_q [TORQUE_POINTS];
  logic [AFPB_DW-1:0] live_close_d [TORQUE_POINTS];
  logic [AFPB_DW-1:0] shown_open_q [TORQUE_POINTS];
  logic [AFPB_DW-1:0] shown_open_d [TORQUE_POINTS];
  logic [AFPB_DW-1:0] shown_close_q [TORQUE_POINTS];
  logic [AFPB_DW-1:0] shown_close_d [TORQUE_POINTS];
  logic [AFPB_DW-1:0] live_cnt_open_q, live_cnt_open_d;
  logic [AFPB_DW-1:0] live_cnt_close_q, live_cnt_close_d;
  logic [AFPB_DW-1:0] cnt_open_q, cnt_open_d;
  logic [AFPB_DW-1:0] cnt_close_q, cnt_close_d;
  logic [AFPB_DW-1:0] lim_close_q, lim_close_d;
  logic [AFPB_DW-1:0] lim_open_q, lim_open_d;

  logic wr_ctrl, clr_open, clr_close, log_reset, refresh;
  logic [4:0] su_idx, bus_su_idx;
  logic [3:0] rd_open_idx, rd_close_idx;

  assign wr_ctrl = par_wr && (par_addr == ADDR_OUTPUT_CONTROL);
  // Action bits act once per write and never stick
  assign log_reset = wr_ctrl && par_wdata[OUT_LOG_RESET_BIT];
  assign clr_open = wr_ctrl && par_wdata[OUT_CLR_OPEN_BIT];
  assign clr_close = wr_ctrl && par_wdata[OUT_CLR_CLOSE_BIT];
  assign su_idx = 5'(startup_index - ADDR_STARTUP_FIRST);
  assign bus_su_idx = 5'(par_addr - ADDR_STARTUP_FIRST);
  assign rd_open_idx = 4'(par_addr - ADDR_OPEN_TORQUE_FIRST);
  assign rd_close_idx = 4'(par_addr - ADDR_CLOSE_TORQUE_FIRST);

  // Settings and read path
  always_comb begin
    permit_d = permit_q;
    cmd_d = cmd_q;
    demand_d = demand_q;
    cmd_stb_d = 1'b0;
    portcmd_d = portcmd_q;
    port_stb_d = 1'b0;
    relay_d = relay_q;
    scale_d = scale_q;
    pcount_d = pcount_q;
    pmask_d = pmask_q;
    config_d = config_q;
    startup_d = startup_q;
    rdata_d = WORD_ZERO;

    // Ignored entirely while permit is anything but 1
    if (startup_wr && (permit_q == PERMIT_ALLOW) &&
        afpb_in_range(startup_index, ADDR_STARTUP_FIRST, STARTUP_COUNT)) begin
      startup_d[su_idx] = startup_data;
    end
    // Only the start-up configuration stage sets this
    if (startup_cfg_valid && (startup_cfg >= CONFIG_MIN) && (startup_cfg <= CONFIG_MAX)) begin
      config_d = startup_cfg;
    end

    if (par_wr) begin
      if (afpb_in_range(par_addr, ADDR_STARTUP_FIRST, STARTUP_COUNT)) begin
        startup_d[bus_su_idx] = par_wdata;
      end
      case (par_addr)
        ADDR_STARTUP_PERMIT: begin
          permit_d = par_wdata;
        end
        ADDR_ACTUATOR_COMMAND: begin
          cmd_d = par_wdata;
          cmd_stb_d = 1'b1;
        end
        ADDR_POSITION_DEMAND: begin
          demand_d = par_wdata;
          cmd_stb_d = 1'b1;
        end
        ADDR_PORT_COMMAND: begin
          portcmd_d = par_wdata;
          port_stb_d = 1'b1;
        end
        ADDR_OUTPUT_CONTROL: begin
          relay_d = par_wdata[OUT_RELAY_W-1:0];
        end
        ADDR_ANALOGUE_SCALE: begin
          scale_d = par_wdata;
        end
        ADDR_PORT_COUNT: begin
          if ((par_wdata >= PORT_COUNT_MIN) && (par_wdata <= PORT_COUNT_MAX)) begin
            pcount_d = par_wdata;
          end
        end
        ADDR_ACTIVE_PORT_MASK: begin
          pmask_d = (par_wdata & ACTIVE_MASK_VALID) | ACTIVE_MASK_PORT1;
        end
        default: begin
        end
      endcase
    end

    if (par_rd) begin
      if (afpb_in_range(par_addr, ADDR_STARTUP_FIRST, STARTUP_COUNT)) begin
        rdata_d = startup_q[bus_su_idx];
      end else if (afpb_in_range(par_addr, ADDR_OPEN_TORQUE_FIRST, TORQUE_POINTS)) begin
        rdata_d = shown_open_q[rd_open_idx];
      end else if (afpb_in_range(par_addr, ADDR_CLOSE_TORQUE_FIRST, TORQUE_POINTS)) begin
        rdata_d = shown_close_q[rd_close_idx];
      end else begin
        case (par_addr)
          ADDR_INTERFACE_TYPE: rdata_d = IFACE_TYPE_CODE;
          ADDR_STARTUP_PERMIT: rdata_d = permit_q;
          ADDR_ACTUATOR_COMMAND: rdata_d = cmd_q;
          ADDR_POSITION_DEMAND: rdata_d = demand_q;
          ADDR_PORT_COMMAND: rdata_d = portcmd_q;
          ADDR_OUTPUT_CONTROL: rdata_d = {12'h000, relay_q};
          ADDR_STATUS_WORD_A: rdata_d = fb_status_a;
          ADDR_STATUS_WORD_B: rdata_d = fb_status_b;
          ADDR_TORQUE_FEEDBACK: rdata_d = fb_torque;
          ADDR_VALVE_POSITION: rdata_d = fb_position;
          ADDR_TEMPERATURE: rdata_d = fb_temperature;
          ADDR_ANALOGUE_SCALE: rdata_d = scale_q;
          ADDR_ANALOGUE_VALUE: rdata_d = fb_analogue;
          ADDR_MULTIPORT_POSITION: rdata_d = fb_multiport;
          ADDR_PORT_COUNT: rdata_d = pcount_q;
          ADDR_ACTIVE_PORT_MASK: rdata_d = pmask_q;
          ADDR_SELECTED_CONFIG: rdata_d = config_q;
          ADDR_CLOSE_TORQUE_LIMIT: rdata_d = lim_close_q;
          ADDR_OPEN_TORQUE_LIMIT: rdata_d = lim_open_q;
          ADDR_CLOSE_START_COUNTER: rdata_d = cnt_close_q;
          ADDR_OPEN_START_COUNTER: rdata_d = cnt_open_q;
          default: rdata_d = WORD_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      permit_q <= PERMIT_RST;
      cmd_q <= WORD_ZERO;
      demand_q <= WORD_ZERO;
      cmd_stb_q <= 1'b0;
      portcmd_q <= WORD_ZERO;
      port_stb_q <= 1'b0;
      relay_q <= '0;
      scale_q <= WORD_ZERO;
      pcount_q <= PORT_COUNT_RST;
      pmask_q <= ACTIVE_MASK_PORT1;
      config_q <= WORD_ZERO;
      rdata_q <= WORD_ZERO;
      for (int i = 0; i < STARTUP_COUNT; i++) begin
        startup_q[i] <= WORD_ZERO;
      end
    end else begin
      permit_q <= permit_d;
      cmd_q <= cmd_d;
      demand_q <= demand_d;
      cmd_stb_q <= cmd_stb_d;
      portcmd_q <= portcmd_d;
      port_stb_q <= port_stb_d;
      relay_q <= relay_d;
      scale_q <= scale_d;
      pcount_q <= pcount_d;
      pmask_q <= pmask_d;
      config_q <= config_d;
      rdata_q <= rdata_d;
      startup_q <= startup_d;
    end
  end

  // Logger: live capture whether moving or not, published after a settled stop in remote
  assign refresh = (state_q == AFPB_LOG_SETTLE) && !act_moving &&
                   (settle_q == 32'(SETTLE_CYCLES - 1)) && act_remote;

  always_comb begin
    state_d = state_q;
    settle_d = settle_q;
    live_open_d = live_open_q;
    live_close_d = live_close_q;
    shown_open_d = shown_open_q;
    shown_close_d = shown_close_q;
    live_cnt_open_d = live_cnt_open_q;
    live_cnt_close_d = live_cnt_close_q;
    cnt_open_d = cnt_open_q;
    cnt_close_d = cnt_close_q;
    lim_close_d = lim_close_q;
    lim_open_d = lim_open_q;

    case (state_q)
      AFPB_LOG_IDLE: begin
        if (act_moving) begin
          state_d = AFPB_LOG_MOVING;
        end
      end
      AFPB_LOG_MOVING: begin
        if (!act_moving) begin
          state_d = AFPB_LOG_SETTLE;
          settle_d = 32'h0000_0000;
        end
      end
      AFPB_LOG_SETTLE: begin
        if (act_moving) begin
          state_d = AFPB_LOG_MOVING;
        end else if (settle_q == 32'(SETTLE_CYCLES - 1)) begin
          // Outside remote the stop is skipped, old log stays
          state_d = AFPB_LOG_IDLE;
        end else begin
          settle_d = settle_q + 32'h0000_0001;
        end
      end
      default: begin
        state_d = AFPB_LOG_IDLE;
      end
    endcase

    if (refresh) begin
      shown_open_d = live_open_q;
      shown_close_d = live_close_q;
      cnt_open_d = live_cnt_open_q;
      cnt_close_d = live_cnt_close_q;
      lim_close_d = torque_limit_close;
      lim_open_d = torque_limit_open;
    end

    if (log_reset) begin
      for (int i = 0; i < TORQUE_POINTS; i++) begin
        live_open_d[i] = WORD_ZERO;
        live_close_d[i] = WORD_ZERO;
        shown_open_d[i] = WORD_ZERO;
        shown_close_d[i] = WORD_ZERO;
      end
    end
    if (clr_open || log_reset) begin
      live_cnt_open_d = WORD_ZERO;
      cnt_open_d = WORD_ZERO;
    end
    if (clr_close || log_reset) begin
      live_cnt_close_d = WORD_ZERO;
      cnt_close_d = WORD_ZERO;
    end

    // Applied after clears so a same-cycle event survives
    if (start_open) begin
      live_cnt_open_d = (clr_open || log_reset) ? 16'h0001 : live_cnt_open_q + 16'h0001;
    end
    if (start_close) begin
      live_cnt_close_d = (clr_close || log_reset) ? 16'h0001 : live_cnt_close_q + 16'h0001;
    end
    if (open_torque_valid && (torque_point < 4'(TORQUE_POINTS))) begin
      live_open_d[torque_point] = torque_value;
    end
    if (close_torque_valid && (torque_point < 4'(TORQUE_POINTS))) begin
      live_close_d[torque_point] = torque_value;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= AFPB_LOG_IDLE;
      settle_q <= 32'h0000_0000;
      live_cnt_open_q <= WORD_ZERO;
      live_cnt_close_q <= WORD_ZERO;
      cnt_open_q <= WORD_ZERO;
      cnt_close_q <= WORD_ZERO;
      lim_close_q <= WORD_ZERO;
      lim_open_q <= WORD_ZERO;
      for (int i = 0; i < TORQUE_POINTS; i++) begin
        live_open_q[i] <= WORD_ZERO;
        live_close_q[i] <= WORD_ZERO;
        shown_open_q[i] <= WORD_ZERO;
        shown_close_q[i] <= WORD_ZERO;
      end
    end else begin
      state_q <= state_d;
      settle_q <= settle_d;
      live_open_q <= live_open_d;
      live_close_q <= live_close_d;
      shown_open_q <= shown_open_d;
      shown_close_q <= shown_close_d;
      live_cnt_open_q <= live_cnt_open_d;
      live_cnt_close_q <= live_cnt_close_d;
      cnt_open_q <= cnt_open_d;
      cnt_close_q <= cnt_close_d;
      lim_close_q <= lim_close_d;
      lim_open_q <= lim_open_d;
    end
  end

  assign par_rdata = rdata_q;
  assign actuator_command = cmd_q;
  assign position_demand = demand_q;
  assign command_strobe = cmd_stb_q;
  assign port_command = portcmd_q;
  assign port_strobe = port_stb_q;
  assign relay_out = relay_q;
  assign analogue_scale = scale_q;
  assign port_count = pcount_q;
  assign active_port_mask = pmask_q;
  assign startup_value_out = startup_q;

endmodule

/* inc/afpb_pkg.sv */
/*
  Constants, offsets, field positions and types for the actuator fieldbus
  parameter bank. Assumes a single 25 MHz clock domain shared by all users.
*/
package afpb_pkg;

  localparam int AFPB_AW = 8;
  localparam int AFPB_DW = 16;

  // Parameter numbers, used directly as addresses
  localparam logic [7:0] ADDR_STARTUP_FIRST = 8'h01;
  localparam logic [7:0] ADDR_STARTUP_LAST = 8'h13;
  localparam logic [7:0] ADDR_INTERFACE_TYPE = 8'h18;
  localparam logic [7:0] ADDR_STARTUP_PERMIT = 8'h19;
  localparam logic [7:0] ADDR_ACTUATOR_COMMAND = 8'h1A;
  localparam logic [7:0] ADDR_POSITION_DEMAND = 8'h1B;
  localparam logic [7:0] ADDR_PORT_COMMAND = 8'h1C;
  localparam logic [7:0] ADDR_OUTPUT_CONTROL = 8'h1D;
  localparam logic [7:0] ADDR_STATUS_WORD_A = 8'h1E;
  localparam logic [7:0] ADDR_STATUS_WORD_B = 8'h1F;
  localparam logic [7:0] ADDR_TORQUE_FEEDBACK = 8'h20;
  localparam logic [7:0] ADDR_VALVE_POSITION = 8'h21;
  localparam logic [7:0] ADDR_TEMPERATURE = 8'h22;
  localparam logic [7:0] ADDR_ANALOGUE_SCALE = 8'h23;
  localparam logic [7:0] ADDR_ANALOGUE_VALUE = 8'h24;
  localparam logic [7:0] ADDR_MULTIPORT_POSITION = 8'h25;
  localparam logic [7:0] ADDR_PORT_COUNT = 8'h26;
  localparam logic [7:0] ADDR_ACTIVE_PORT_MASK = 8'h27;
  localparam logic [7:0] ADDR_SELECTED_CONFIG = 8'h28;
  localparam logic [7:0] ADDR_CLOSE_TORQUE_LIMIT = 8'h2A;
  localparam logic [7:0] ADDR_OPEN_TORQUE_LIMIT = 8'h2B;
  localparam logic [7:0] ADDR_OPEN_TORQUE_FIRST = 8'h2C;
  localparam logic [7:0] ADDR_CLOSE_TORQUE_FIRST = 8'h37;
  localparam logic [7:0] ADDR_CLOSE_START_COUNTER = 8'h42;
  localparam logic [7:0] ADDR_OPEN_START_COUNTER = 8'h43;

  localparam int STARTUP_COUNT = 19;
  localparam int TORQUE_POINTS = 11;

  // Output-control field layout
  localparam int OUT_RELAY_W = 4;
  localparam int OUT_CLR_OPEN_BIT = 10;
  localparam int OUT_CLR_CLOSE_BIT = 11;
  localparam int OUT_LOG_RESET_BIT = 12;

  // Active-port mask: ten ports, port 1 in bit 0
  localparam logic [15:0] ACTIVE_MASK_VALID = 16'h03FF;
  localparam logic [15:0] ACTIVE_MASK_PORT1 = 16'h0001;

  // Reset values and limits
  localparam logic [15:0] PERMIT_RST = 16'h0001;
  localparam logic [15:0] PERMIT_ALLOW = 16'h0001;
  localparam logic [15:0] PORT_COUNT_MIN = 16'h0002;
  localparam logic [15:0] PORT_COUNT_MAX = 16'h000A;
  localparam logic [15:0] PORT_COUNT_RST = 16'h0002;
  localparam logic [15:0] CONFIG_MIN = 16'h0001;
  localparam logic [15:0] CONFIG_MAX = 16'h000A;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int LOG_SETTLE_MS = 100;
  localparam int LOG_SETTLE_CYCLES = (CLK_HZ / 1000) * LOG_SETTLE_MS;

  typedef enum logic [1:0] {
    AFPB_LOG_IDLE = 2'b00,
    AFPB_LOG_MOVING = 2'b01,
    AFPB_LOG_SETTLE = 2'b11
  } afpb_log_state_t;

  function automatic logic afpb_in_range(input logic [7:0] addr, input logic [7:0] first, input int count);
    logic [7:0] last;
    last = 8'(int'(first) + count - 1);
    return (addr >= first) && (addr <= last);
  endfunction

endpackage

/* testbench/afpb_bank_assertions.sv */
/*
  Port checker for the parameter bank.
  Assumes it is bound into afpb_bank: one clock, synchronous reset.
*/
`timescale 1ns/1ps
module afpb_bank_assertions #(
  parameter logic [15:0] IFACE_TYPE_CODE = 16'h00A5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Parameter access
  input wire logic [7:0] par_addr,
  input wire logic [15:0] par_wdata,
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic [15:0] par_rdata,
  // Feedback
  input wire logic [15:0] fb_torque,
  input wire logic [15:0] fb_multiport,
  // Control outputs
  input wire logic [15:0] actuator_command,
  input wire logic command_strobe,
  input wire logic [15:0] port_command,
  input wire logic port_strobe,
  input wire logic [3:0] relay_out,
  input wire logic [15:0] analogue_scale,
  input wire logic [15:0] port_count,
  input wire logic [15:0] active_port_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_iface_type:
    assert property (par_rd && par_addr == 8'h18 |=> par_rdata == IFACE_TYPE_CODE) else $error("type code wrong");
  a_command_store:
    assert property (par_wr && par_addr == 8'h1A |=> actuator_command == $past(par_wdata) && command_strobe)
    else $error("command not stored");
  a_port_store:
    assert property (par_wr && par_addr == 8'h1C |=> port_command == $past(par_wdata) && port_strobe)
    else $error("port command not stored");
  a_relay_drive:
    assert property (par_wr && par_addr == 8'h1D |=> relay_out == 4'($past(par_wdata))) else $error("relay wrong");
  a_scale_write:
    assert property (par_wr && par_addr == 8'h23 |=> analogue_scale == $past(par_wdata)) else $error("scale wrong");
  a_count_range:
    assert property (port_count >= 16'h0002 && port_count <= 16'h000A) else $error("port count out of range");
  a_count_reject:
    assert property (par_wr && par_addr == 8'h26 && (par_wdata < 16'h0002 || par_wdata > 16'h000A)
      |=> $stable(port_count)) else $error("bad port count taken");
  a_mask_write:
    assert property (par_wr && par_addr == 8'h27 |=> active_port_mask == (($past(par_wdata) & 16'h03FF) | 16'h0001))
    else $error("mask wrong");
  a_port_one:
    assert property (active_port_mask[0] && active_port_mask[15:10] == 6'h00) else $error("port 1 inactive");
  a_torque_mirror:
    assert property (par_rd && par_addr == 8'h20 |=> par_rdata == $past(fb_torque)) else $error("torque mirror");
  a_multi_mirror:
    assert property (par_rd && par_addr == 8'h25 |=> par_rdata == $past(fb_multiport)) else $error("multiport mirror");
endmodule

/* testbench/afpb_bank_test.sv */
/*
  Self-checking bench for afpb_bank: bus tasks, start-up master, logger.
  Assumes the master model and checker are compiled before this file.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module afpb_bank_test;
  import afpb_pkg::*;
  localparam int ST = 8;
  localparam logic [15:0] CODE = 16'h00A5; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] par_addr = 8'h00;
  logic [15:0] par_wdata = 16'h0000;
  logic par_wr = 1'b0;
  logic par_rd = 1'b0;
  logic go = 1'b0;
  logic [15:0] base = 16'h0000;
  logic moving = 1'b0;
  logic remote = 1'b0;
  logic otv = 1'b0;
  logic ctv = 1'b0;
  logic st_o = 1'b0;
  logic st_c = 1'b0;
  logic [3:0] tpt = 4'h0;
  logic [15:0] tval = 16'h0000;
  logic [15:0] tlc = 16'h0C01;
  logic [15:0] tlo = 16'h0C02;
  logic s_wr, c_valid, done, command_strobe, port_strobe;
  logic [7:0] s_idx;
  logic [3:0] relay_out;
  logic [15:0] par_rdata, s_data, cfg, actuator_command, position_demand, port_command;
  logic [15:0] analogue_scale, port_count, active_port_mask;
  logic [15:0] fb [7];
  logic [7:0] fba [7] = '{8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h24, 8'h25};
  logic [15:0] svo [19];
  int error_cnt = 0;
  int comparisons = 0;

  always #20 clk = ~clk;

  afpb_master_model master (.clk(clk), .go(go), .base(base), .startup_wr(s_wr), .startup_index(s_idx),
    .startup_data(s_data), .startup_cfg_valid(c_valid), .startup_cfg(cfg), .done(done));

  afpb_bank #(.SETTLE_CYCLES(ST), .IFACE_TYPE_CODE(CODE)) uut (.clk(clk), .rst(rst),
    .par_addr(par_addr), .par_wdata(par_wdata), .par_wr(par_wr), .par_rd(par_rd), .par_rdata(par_rdata),
    .startup_wr(s_wr), .startup_index(s_idx), .startup_data(s_data), .startup_cfg_valid(c_valid),
    .startup_cfg(cfg), .fb_status_a(fb[0]), .fb_status_b(fb[1]), .fb_torque(fb[2]), .fb_position(fb[3]),
    .fb_temperature(fb[4]), .fb_analogue(fb[5]), .fb_multiport(fb[6]), .act_moving(moving),
    .act_remote(remote), .torque_limit_close(tlc), .torque_limit_open(tlo),
    .open_torque_valid(otv), .close_torque_valid(ctv), .torque_point(tpt), .torque_value(tval),
    .start_close(st_c), .start_open(st_o), .actuator_command(actuator_command),
    .position_demand(position_demand), .command_strobe(command_strobe), .port_command(port_command),
    .port_strobe(port_strobe), .relay_out(relay_out), .analogue_scale(analogue_scale),
    .port_count(port_count), .active_port_mask(active_port_mask), .startup_value_out(svo));

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    par_wr <= 1'b1;
    par_addr <= a;
    par_wdata <= d;
    @(posedge clk);
    par_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    par_rd <= 1'b1;
    par_addr <= a;
    @(posedge clk);
    par_rd <= 1'b0;
    #1;
    `CHK(par_rdata, e)
  endtask

  task automatic tally_and_finish;
    $display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic boot(input logic [15:0] b);
    int n;
    n = 0;
    @(posedge clk);
    go <= 1'b1;
    base <= b;
    @(posedge clk);
    go <= 1'b0;
    while (!done && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  // Runs a stop with settle time, remote or not
  task automatic stop_and_settle;
    @(posedge clk);
    moving <= 1'b0;
    repeat (ST + 3) @(posedge clk);
  endtask

  initial begin
    for (int i = 0; i < 7; i++)
      fb[i] = 16'h3000 + 16'(i * 273);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h19, 16'h0001);
    rd(8'h18, CODE);
    wr(8'h18, 16'h1234);
    rd(8'h18, CODE);
    boot(16'hA000);
    for (int i = 1; i < 20; i++)
      `CHK(svo[i-1], 16'hA000 + 16'(i))
    rd(8'h05, 16'hA005);
    rd(8'h28, 16'h0003);
    wr(8'h28, 16'h0007);
    rd(8'h28, 16'h0003);
    // Permit 2 must block as firmly as 0
    wr(8'h19, 16'h0002);
    boot(16'hB000);
    rd(8'h13, 16'hA013);
    wr(8'h19, 16'h0001);
    boot(16'hC000);
    `CHK(svo[0], 16'hC001)
    for (int i = 0; i < 4; i++) begin
      wr(8'h1A, 16'(i));
      `CHK(actuator_command, 16'(i))
      wr(8'h1D, 16'h0001 << i);
      `CHK(relay_out, 4'h1 << i)
    end
    wr(8'h1B, 16'h0064);
    `CHK(position_demand, 16'h0064)
    rd(8'h1B, 16'h0064);
    wr(8'h1C, 16'h0005);
    rd(8'h1C, 16'h0005);
    wr(8'h1D, 16'hE3F5);
    rd(8'h1D, 16'h0005);
    for (int i = 0; i < 7; i++)
      rd(fba[i], fb[i]);
    wr(8'h23, 16'h0ABC);
    rd(8'h23, 16'h0ABC);
    wr(8'h26, 16'h000A);
    wr(8'h26, 16'h000B);
    rd(8'h26, 16'h000A);
    wr(8'h26, 16'h0001);
    rd(8'h26, 16'h000A);
    wr(8'h26, 16'h0002);
    rd(8'h26, 16'h0002);
    wr(8'h27, 16'hFC2C);
    rd(8'h27, 16'h002D);
    rd(8'h50, 16'h0000);
    @(posedge clk);
    moving <= 1'b1;
    remote <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      st_o <= 1'b1;
      st_c <= (i < 2);
      @(posedge clk);
      st_o <= 1'b0;
      st_c <= 1'b0;
    end
    for (int j = 0; j < 2; j++)
      for (int i = 0; i < 11; i++) begin
        @(posedge clk);
        otv <= (j == 0);
        ctv <= (j == 1);
        tpt <= 4'(i);
        tval <= 16'h0100 * 16'(j + 1) + 16'(i);
      end
    @(posedge clk);
    otv <= 1'b0;
    ctv <= 1'b0;
    rd(8'h43, 16'h0000);
    stop_and_settle();
    rd(8'h42, 16'h0002);
    rd(8'h43, 16'h0003);
    rd(8'h2A, 16'h0C01);
    rd(8'h2B, 16'h0C02);
    for (int i = 0; i < 11; i++) begin
      rd(8'h2C + 8'(i), 16'h0100 + 16'(i));
      rd(8'h37 + 8'(i), 16'h0200 + 16'(i));
    end
    @(posedge clk);
    remote <= 1'b0;
    moving <= 1'b1;
    st_o <= 1'b1;
    // New limits must not reach the view outside remote
    tlc <= 16'h0C11;
    tlo <= 16'h0C12;
    @(posedge clk);
    st_o <= 1'b0;
    stop_and_settle();
    rd(8'h43, 16'h0003);
    rd(8'h2A, 16'h0C01);
    rd(8'h2B, 16'h0C02);
    wr(8'h1D, 16'h0400);
    rd(8'h43, 16'h0000);
    rd(8'h42, 16'h0002);
    wr(8'h1D, 16'h0800);
    rd(8'h42, 16'h0000);
    wr(8'h1D, 16'h1000);
    rd(8'h2C, 16'h0000);
    rd(8'h41, 16'h0000);
    rd(8'h2A, 16'h0C01);
    tally_and_finish();
  end
endmodule

bind afpb_bank afpb_bank_assertions #(.IFACE_TYPE_CODE(IFACE_TYPE_CODE)) chk (.clk(clk), .rst(rst),
  .par_addr(par_addr), .par_wdata(par_wdata), .par_wr(par_wr), .par_rd(par_rd), .par_rdata(par_rdata),
  .fb_torque(fb_torque), .fb_multiport(fb_multiport), .actuator_command(actuator_command),
  .command_strobe(command_strobe), .port_command(port_command), .port_strobe(port_strobe),
  .relay_out(relay_out), .analogue_scale(analogue_scale), .port_count(port_count),
  .active_port_mask(active_port_mask));

/* testbench/afpb_master_model.sv */
/*
  Behavioural start-up master: on go it sends the chosen configuration,
  then one value for each of parameters 1 to 19.
  Assumes go is a one-cycle pulse on clk with base valid beside it.
*/
`timescale 1ns/1ps
module afpb_master_model #(
  parameter logic [15:0] CFG = 16'h0003
) (
  // Clock and request
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] base,
  // Start-up port
  output logic startup_wr,
  output logic [7:0] startup_index,
  output logic [15:0] startup_data,
  output logic startup_cfg_valid,
  output logic [15:0] startup_cfg,
  // Completion
  output logic done
);
  logic [15:0] b;
  initial begin
    startup_wr = 1'b0;
    startup_index = 8'h00;
    startup_data = 16'h0000;
    startup_cfg_valid = 1'b0;
    startup_cfg = 16'h0000;
    done = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        b = base;
        startup_cfg_valid <= 1'b1;
        startup_cfg <= CFG;
        @(posedge clk);
        startup_cfg_valid <= 1'b0;
        startup_cfg <= ~CFG;
        for (int i = 1; i < 20; i++) begin
          startup_wr <= 1'b1;
          startup_index <= 8'(i);
          startup_data <= b + 16'(i);
          @(posedge clk);
        end
        // Released lines carry junk, so stale values cannot pass
        startup_wr <= 1'b0;
        startup_index <= ~startup_index;
        startup_data <= ~startup_data;
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
      end
    end
  end
endmodule
